// [rtl/module_bus_address_decode.sv]
// Module bus address decoder with array relocation and module map control.
`timescale 1ns/1ps
module module_bus_address_decode
  import bus_decode_pkg::*;
(
  // Clock and reset.
  input  wire logic                  i_clock,
  input  wire logic                  i_resetn,
  // Processor request.
  input  wire logic                  i_req,
  input  wire logic                  i_write,
  input  wire logic [CPU_ADDR_W-1:0] i_addr,
  input  wire logic [BUS_DATA_W-1:0] i_wdata,
  // Configuration from the integration and RAM control blocks.
  input  wire logic                  i_module_map_bit,
  input  wire logic                  i_ram_enable_set,
  input  wire logic                  i_ram_disable,
  input  wire logic [23:0]           i_ram_base,
  input  wire logic [23:0]           i_rom_base,
  // Module bus outputs.
  output logic [BUS_ADDR_W-1:0]      o_bus_addr,
  output logic [BUS_DATA_W-1:0]      o_bus_wdata,
  output logic                       o_bus_write,
  output logic                       o_sel_ram,
  output logic                       o_sel_rom,
  output logic                       o_sel_modreg,
  output logic                       o_sel_external,
  output logic                       o_bus_error,
  // Test pins and status.
  output logic [EXT_BITS-1:0]        o_test_addr_hi,
  output logic                       o_ram_enabled,
  output logic                       o_modules_locked
);

  // ==========================================================================
  // Address extension
  // The processor drives only the lower lines of the bus. Each upper line
  // repeats the top processor bit, which is why the processor alone can never
  // land in the inaccessible range.
  logic [BUS_ADDR_W-1:0] full_addr;

  assign full_addr[CPU_ADDR_W-1:0] = i_addr;

  // One copy of the top processor bit for every upper bus line.
  for (genvar g = CPU_ADDR_W; g < BUS_ADDR_W; g++) begin : g_upper
    assign full_addr[g] = i_addr[SIGN_BIT];
  end

  // The compare unit sees the extended address and both base values.
  addr_map_if map ();
  assign map.addr     = full_addr;
  assign map.ram_base = i_ram_base;
  assign map.rom_base = i_rom_base;

  // Array hits come back combinationally and meet the priority chain below.
  array_match u_match (
    .m (map.matcher)
  );

  // ==========================================================================
  // Control state
  logic ram_en_q;
  logic locked_q;

  // RAM array stays off from reset until software turns it on.
  // Disable beats enable when both arrive together, the safer of the two.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      ram_en_q <= 1'b0;
    end else if (i_ram_disable) begin
      ram_en_q <= 1'b0;
    end else if (i_ram_enable_set) begin
      ram_en_q <= 1'b1;
    end
  end

  // The lock is sticky so a later set of the map bit cannot reopen modules.
  // The map bit is looked at every cycle, so even a one-cycle low closes them.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      locked_q <= 1'b0;
    end else if (!i_module_map_bit) begin
      locked_q <= 1'b1;
    end
  end

  // ==========================================================================
  // Decode
  logic    in_hole;
  logic    mod_hit;
  logic    mod_ok;
  logic    ram_ok;
  logic    rom_ok;
  target_e tgt;

  // The processor alone never reaches this range; the check still guards the
  // selects should another master ever drive the upper lines.
  assign in_hole = (full_addr >= HOLE_LO) && (full_addr <= HOLE_HI);
  // The register block nibble is the map bit followed by three ones.
  assign mod_hit = (full_addr[BUS_ADDR_W-1:CPU_ADDR_W] == {i_module_map_bit, MODREG_ONES})
                && (full_addr[SIGN_BIT:MODREG_SPAN_W]
                    == {(CPU_ADDR_W-MODREG_SPAN_W){1'b1}});
  // Only the full F nibble is legal in this device.
  assign mod_ok  = mod_hit && !locked_q && i_module_map_bit
                && ({i_module_map_bit, MODREG_ONES} == MODREG_NIBBLE);
  // A disabled RAM array stays silent and lets ROM or the external bus answer.
  assign ram_ok  = map.ram_hit && ram_en_q;
  assign rom_ok  = map.rom_hit;

  // Priority: hole, module registers, RAM, ROM, then external.
  always_comb begin
    tgt = TGT_NONE;
    if (i_req) begin
      if (in_hole) begin
        tgt = TGT_ERROR;
      end else if (mod_ok) begin
        tgt = TGT_MODREG;
      end else if (ram_ok) begin
        tgt = TGT_RAM;
      end else if (rom_ok) begin
        tgt = TGT_ROM;
      end else begin
        tgt = TGT_EXTERNAL;
      end
    end
  end

  // ==========================================================================
  // Registered outputs
  // Address lines hold the last request, so a slow target still sees them.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_bus_addr <= '0;
    end else if (i_req) begin
      o_bus_addr <= full_addr;
    end
  end

  // Write data rides with the address; only sixteen data lines exist.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_bus_wdata <= '0;
    end else if (i_req) begin
      o_bus_wdata <= i_wdata;
    end
  end

  // Direction of the access is taken together with the request.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_bus_write <= 1'b0;
    end else if (i_req) begin
      o_bus_write <= i_write;
    end
  end

  // Test pins only mirror the upper lines; nothing inside decodes from them.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_test_addr_hi <= '0;
    end else if (i_req) begin
      o_test_addr_hi <= full_addr[BUS_ADDR_W-1:CPU_ADDR_W];
    end
  end

  // ==========================================================================
  // Target selects
  // Selects are high in the cycle after each request cycle; a hole access selects none of them.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_sel_ram      <= 1'b0;
      o_sel_rom      <= 1'b0;
      o_sel_modreg   <= 1'b0;
      o_sel_external <= 1'b0;
    end else begin
      o_sel_ram      <= (tgt == TGT_RAM);
      o_sel_rom      <= (tgt == TGT_ROM);
      o_sel_modreg   <= (tgt == TGT_MODREG);
      o_sel_external <= (tgt == TGT_EXTERNAL);
    end
  end

  // The error pulse stands in for a response the bus itself does not define.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_bus_error <= 1'b0;
    end else begin
      o_bus_error <= (tgt == TGT_ERROR);
    end
  end

  // ==========================================================================
  // Status
  // RAM enable copy; it trails the internal state by one cycle.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_ram_enabled <= 1'b0;
    end else begin
      o_ram_enabled <= ram_en_q;
    end
  end

  // Lock copy; it also trails the internal state by one cycle.
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      o_modules_locked <= 1'b0;
    end else begin
      o_modules_locked <= locked_q;
    end
  end

endmodule

// [rtl/bus_decode_pkg.sv]
// Package of address map constants for the module bus decoder.
package bus_decode_pkg;

  // ==========================================================================
  // Bus widths
  localparam int CPU_ADDR_W  = 20;
  localparam int BUS_ADDR_W  = 24;
  localparam int BUS_DATA_W  = 16;
  localparam int EXT_BITS    = BUS_ADDR_W - CPU_ADDR_W;
  localparam int SIGN_BIT    = CPU_ADDR_W - 1;

  // ==========================================================================
  // Address map
  localparam logic [23:0] HOLE_LO       = 24'h080000;
  localparam logic [23:0] HOLE_HI       = 24'hf7ffff;
  localparam logic [2:0]  MODREG_ONES   = 3'h7;
  localparam logic [3:0]  MODREG_NIBBLE = 4'hf;
  localparam int          MODREG_SPAN_W = 12;
  localparam int          ARRAY_SPAN_W  = 11;
  localparam int          ROM_SPAN_W    = 14;

  // Reset values.
  localparam logic [23:0] RAM_BASE_RST  = 24'hfff000;
  localparam logic [23:0] ROM_BASE_RST  = 24'hff0000;

  // Target selection.
  typedef enum logic [2:0] {
    TGT_NONE,
    TGT_RAM,
    TGT_ROM,
    TGT_MODREG,
    TGT_EXTERNAL,
    TGT_ERROR
  } target_e;

endpackage

// [rtl/addr_map_if.sv]
// Interface carrying the array placement between decoder and compare unit.
`timescale 1ns/1ps
interface addr_map_if;
  import bus_decode_pkg::*;
  logic [23:0] addr;
  logic [23:0] ram_base;
  logic [23:0] rom_base;
  logic        ram_hit;
  logic        rom_hit;
  modport decoder (output addr, output ram_base, output rom_base,
                   input ram_hit, input rom_hit);
  modport matcher (input addr, input ram_base, input rom_base,
                   output ram_hit, output rom_hit);
endinterface

// [rtl/array_match.sv]
// Base compare unit locating the relocatable RAM and ROM arrays.
`timescale 1ns/1ps
module array_match
  import bus_decode_pkg::*;
(
  // Map carrier.
  addr_map_if.matcher m
);
  // Only the bits above each array span are compared, so the arrays align.
  assign m.ram_hit = (m.addr[BUS_ADDR_W-1:ARRAY_SPAN_W]
                      == m.ram_base[BUS_ADDR_W-1:ARRAY_SPAN_W]);
  assign m.rom_hit = (m.addr[BUS_ADDR_W-1:ROM_SPAN_W]
                      == m.rom_base[BUS_ADDR_W-1:ROM_SPAN_W]);
endmodule

// [sim/module_bus_address_decode_assertions.sv]
// Port checker for the module bus address decoder.
`timescale 1ns/1ps
module module_bus_address_decode_assertions
  import bus_decode_pkg::*;
(
  // Watched ports.
  input wire logic        i_clock,
  input wire logic        i_resetn,
  input wire logic        i_req,
  input wire logic [19:0] i_addr,
  input wire logic        i_module_map_bit,
  input wire logic [23:0] o_bus_addr,
  input wire logic        o_sel_ram,
  input wire logic        o_sel_rom,
  input wire logic        o_sel_modreg,
  input wire logic        o_sel_external,
  input wire logic        o_bus_error,
  input wire logic [3:0]  o_test_addr_hi,
  input wire logic        o_modules_locked
);
  // ======
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // A taken request, and the answer that must follow it.
  sequence s_take;
    i_req;
  endsequence
  sequence s_answer;
    $onehot({o_sel_ram, o_sel_rom, o_sel_modreg, o_sel_external, o_bus_error});
  endsequence
  a_upper_sign_copy: assert property (s_take |=>
    o_bus_addr == {{4{$past(i_addr[19])}}, $past(i_addr)}) else $error("upper lines");
  a_one_answer: assert property (s_take |=> s_answer) else $error("answer");
  a_test_pins: assert property (o_test_addr_hi == o_bus_addr[23:20]) else $error("pins");
  a_hole_blocked: assert property (o_bus_addr >= HOLE_LO && o_bus_addr <= HOLE_HI |->
    !(o_sel_ram || o_sel_rom || o_sel_modreg || o_sel_external)) else $error("hole");
  a_lock_sticky: assert property (o_modules_locked |=> o_modules_locked) else $error("lock");
  a_locked_no_module: assert property (o_modules_locked |-> !o_sel_modreg) else $error("lk");
  a_module_nibble: assert property (o_sel_modreg |->
    o_bus_addr[23:20] == MODREG_NIBBLE) else $error("nibble");
  a_map_low_blocks: assert property (i_req && !i_module_map_bit |=> !o_sel_modreg)
    else $error("map low");
endmodule
bind module_bus_address_decode module_bus_address_decode_assertions u_chk (.i_clock,
  .i_resetn, .i_req, .i_addr, .i_module_map_bit, .o_bus_addr, .o_sel_ram, .o_sel_rom,
  .o_sel_modreg, .o_sel_external, .o_bus_error, .o_test_addr_hi, .o_modules_locked);

// [sim/bus_target_model.sv]
// Far side model that records which target answered each access.
`timescale 1ns/1ps
module bus_target_model
  import bus_decode_pkg::*;
(
  // Selects in, last answering target out.
  input  wire logic i_clock,
  input  wire logic [4:0] i_sel,
  output target_e   o_last
);
  // Two selects at once is a conflict a real target bus cannot resolve.
  always_ff @(posedge i_clock) begin
    case (i_sel)
      5'h10: o_last <= TGT_RAM;
      5'h08: o_last <= TGT_ROM;
      5'h04: o_last <= TGT_MODREG;
      5'h02: o_last <= TGT_EXTERNAL;
      5'h01: o_last <= TGT_ERROR;
      5'h00: o_last <= o_last;
      default: o_last <= TGT_NONE;
    endcase
  end
endmodule

// [sim/tb_module_bus_address_decode.sv]
// Self-checking bench for the module bus address decoder.
`timescale 1ns/1ps
module tb_module_bus_address_decode;
  import bus_decode_pkg::*;
  // ======
  logic i_clock = 0, i_resetn = 0, i_req = 0, i_write = 0, i_module_map_bit = 1;
  logic i_ram_enable_set = 0, i_ram_disable = 0, ram_on = 0, locked = 0;
  logic [19:0] i_addr = 0, a;
  logic [15:0] i_wdata = 0, o_bus_wdata;
  logic [23:0] i_ram_base = 24'h07f800, i_rom_base = 24'hff0000, o_bus_addr;
  logic [3:0] o_test_addr_hi;
  logic o_bus_write, o_sel_ram, o_sel_rom, o_sel_modreg, o_sel_external, o_bus_error;
  logic o_ram_enabled, o_modules_locked;
  target_e last;
  int fail_count = 0, num_checks = 0;
  logic [19:0] corner [6] = '{20'h7ffff, 20'h80000, 20'hff000, 20'h7f7ff, 20'hf0000, 20'hfefff};
  module_bus_address_decode i_dut (.i_clock, .i_resetn, .i_req, .i_write, .i_addr, .i_wdata,
    .i_module_map_bit, .i_ram_enable_set, .i_ram_disable, .i_ram_base, .i_rom_base,
    .o_bus_addr, .o_bus_wdata, .o_bus_write, .o_sel_ram, .o_sel_rom, .o_sel_modreg,
    .o_sel_external, .o_bus_error, .o_test_addr_hi, .o_ram_enabled, .o_modules_locked);
  bus_target_model i_model (.i_clock,
    .i_sel({o_sel_ram, o_sel_rom, o_sel_modreg, o_sel_external, o_bus_error}), .o_last(last));
  initial forever #4 i_clock = ~i_clock;
  // Priority is module block, then enabled RAM, then ROM, else the external bus.
  function automatic target_e want(logic [19:0] x);
    logic [23:0] b;
    b = {{4{x[19]}}, x};
    if (b[23:12] == 12'hfff && i_module_map_bit && !locked) return TGT_MODREG;
    if (ram_on && b[23:11] == i_ram_base[23:11]) return TGT_RAM;
    if (b[23:14] == i_rom_base[23:14]) return TGT_ROM;
    return TGT_EXTERNAL;
  endfunction
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // One request; the answer is read two cycles later so latency slips still land.
  task automatic access(logic [19:0] x);
    target_e t;
    t = want(x);
    i_req = 1;
    i_addr = x;
    i_write = 1'($urandom);
    i_wdata = 16'($urandom);
    @(negedge i_clock);
    i_req = 0;
    repeat (2) @(negedge i_clock);
    chk("target", 32'(last), 32'(t));
    chk("bus addr", 32'(o_bus_addr), {8'h0, {4{x[19]}}, x});
    chk("test pins", 32'(o_test_addr_hi), {28'h0, {4{x[19]}}});
    chk("data", 32'({o_bus_write, o_bus_wdata}), 32'({i_write, i_wdata}));
  endtask
  task automatic pulse(logic en, logic dis, logic mm);
    i_ram_enable_set = en;
    i_ram_disable = dis;
    i_module_map_bit = mm;
    @(negedge i_clock);
    {i_ram_enable_set, i_ram_disable, i_module_map_bit} = 3'h1;
    repeat (2) @(negedge i_clock);
  endtask
  initial begin
    void'($urandom(32'h1932));
    repeat (6) @(negedge i_clock);
    i_resetn = 1;
    chk("ram on", 32'(o_ram_enabled), 0);
    access(20'h7f800);
    pulse(1, 1, 1);
    chk("ram on", 32'(o_ram_enabled), 0);
    pulse(1, 0, 1);
    ram_on = 1;
    chk("ram on", 32'(o_ram_enabled), 1);
    for (int k = 0; k < 60; k++) begin
      a = k < 6 ? corner[k] : 20'($urandom);
      if (k >= 6 && k % 3 == 1) a[19:11] = 9'h1ff;
      if (k >= 6 && k % 3 == 2) a[19:11] = 9'h0ff;
      access(a);
    end
    // Relocated arrays: random bases, each probed inside its own span.
    for (int j = 0; j < 8; j++) begin
      i_ram_base = {5'h00, 8'($urandom), 11'h000};
      i_rom_base = {5'h1f, 5'($urandom), 14'h0000};
      access({i_ram_base[19:11], 11'($urandom)});
      access({i_rom_base[19:14], 14'($urandom)});
    end
    locked = 1;
    i_module_map_bit = 0;
    access(20'hff000);
    chk("locked", 32'(o_modules_locked), 1);
    i_module_map_bit = 1;
    access(20'hff000);
    i_resetn = 0;
    repeat (2) @(negedge i_clock);
    i_resetn = 1;
    {ram_on, locked} = 2'h0;
    chk("locked", 32'(o_modules_locked), 0);
    access(20'hff000);
    access(20'h7f800);
    complete_run();
  end
endmodule
